// ===== hw/pam_regs.vh
// register map, field positions and reset values for the port a pin mux block
`ifndef PAM_REGS_VH
`define PAM_REGS_VH
`define PAM_OFS_LEVELS      12'h000
`define PAM_OFS_LATCH       12'h004
`define PAM_OFS_DIR         12'h008
`define PAM_OFS_ADSEL       12'h00c
`define PAM_OFS_CMP         12'h010
`define PAM_OFS_CVR         12'h014
`define PAM_OFS_OSC         12'h018
`define PAM_RST_LATCH       8'h00
`define PAM_RST_DIR         8'hff
`define PAM_RST_ADSEL       8'h00
`define PAM_RST_CMP         8'h07
`define PAM_RST_CVR         8'h00
`define PAM_RST_OSC         3'h0
`define PAM_ADSEL_MASK      8'h3f
`define PAM_CMP_WMASK       8'h3f
`define PAM_CVR_OE_BIT      6
`define PAM_CMP_COMPARATOR_ONE_RESULT_BIT   6
`define PAM_CMP_COMPARATOR_TWO_RESULT_BIT   7
`define PAM_OSC_LP          3'h0
`define PAM_OSC_XT          3'h1
`define PAM_OSC_HS          3'h2
`define PAM_OSC_RC          3'h3
`define PAM_OSC_RC_OSC_WITH_PORT_PIN        3'h4
`define PAM_OSC_INTERNAL_OSC_WITH_PORT_PIN      3'h5
`define PAM_OSC_INTERNAL_OSC_WITH_CLOCK_OUT      3'h6
`define PAM_OSC_EC          3'h7
`define PAM_OSC_EXT_CLOCK_WITH_PORT_PIN        3'h7
`define PAM_CMP_MODE_OFF    3'h7
`define PAM_CMP_MODE_C1C2O  3'h3
`define PAM_CMP_MODE_C1O    3'h5
`endif

// ===== hw/pam_cycle_clk.v
// divide-by-four cycle clock generator
`timescale 1ns/10ps
module pam_cycle_clk
(
    input  wire       pclk,
    input  wire       presetn,
    output reg        cyc_clk
);
    reg [1:0] div_reg;
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_reg <= 2'h0;
            cyc_clk <= 1'b0;
        end
        else
        begin
            div_reg <= div_reg + 2'h1;
            // high for two of every four cycles
            cyc_clk <= (div_reg == 2'h0 || div_reg == 2'h3) ? 1'b1 : 1'b0;
        end
    end
endmodule // pam_cycle_clk

// ===== hw/pam_pin_ctl.v
// per-pin analog/digital decode from the port configuration field
`timescale 1ns/10ps
module pam_pin_ctl
(
    input  wire [3:0] port_config_field,
    output wire [4:0] analog_sel
);
    // analog_sel bit k is analog channel k: pins 0..3 and pin 5
    function [4:0] pcfg_decode;
        input [3:0] f;
        begin
            if (f >= 4'ha)
                pcfg_decode = 5'h00;
            else
                pcfg_decode = 5'h1f >> (f > 4'h5 ? f - 4'h5 : 4'h0);
        end
    endfunction
    assign analog_sel = pcfg_decode(port_config_field);
endmodule // pam_pin_ctl

// ===== hw/pam_port_a.v
// port a register file and pin multiplexer with apb slave
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/10ps
`include "pam_regs.vh"
module pam_port_a
(
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire [7:0]  pin_in,
    output reg  [7:0]  pin_out,
    output reg  [7:0]  pin_oe_n,
    input  wire        comparator_one_result,
    input  wire        comparator_two_result,
    output wire [4:0]  analog_channel_en,
    output wire        comparator_one_inv_in_en,
    output wire        comparator_two_noninv_in_en,
    output wire        comparator_reference_output,
    output wire        timer_zero_clock_in,
    output wire        slave_select_in,
    output wire        oscillator_claims_pins
);
    reg  [7:0]  latch_reg;
    reg  [7:0]  dir_reg;
    reg  [7:0]  adsel_reg;
    reg  [7:0]  cmp_reg;
    reg  [7:0]  cvr_reg;
    reg  [2:0]  osc_reg;
    reg  [31:0] rdata_reg;
    wire [4:0]  analog_sel;
    wire        cyc_clk;
    wire        wr_en;
    wire        rd_en;
    wire        pin6_io;
    wire        pin7_io;
    wire        pin6_clkout;
    wire        cvr_oe;
    wire        c1_route;
    wire        c2_route;
    wire [7:0]  io_mask;
    wire [7:0]  dig_in_dis;
    wire [7:0]  levels;
    wire        addr_ok;

    pam_pin_ctl u_pin_ctl
    (
        .port_config_field (adsel_reg[3:0]),
        .analog_sel        (analog_sel)
    );

    pam_cycle_clk u_cycle_clk
    (
        .pclk    (pclk),
        .presetn (presetn),
        .cyc_clk (cyc_clk)
    );

    function addr_known;
        input [11:0] a;
        begin
            addr_known = (a == `PAM_OFS_LEVELS) || (a == `PAM_OFS_LATCH) ||
                         (a == `PAM_OFS_DIR) || (a == `PAM_OFS_ADSEL) ||
                         (a == `PAM_OFS_CMP) || (a == `PAM_OFS_CVR) ||
                         (a == `PAM_OFS_OSC);
        end
    endfunction

    // zero-wait slave; unmapped addresses answer with pslverr
    assign addr_ok = addr_known(paddr);
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~addr_ok;
    assign wr_en   = psel & penable & pwrite & addr_ok;
    assign rd_en   = psel & ~penable & ~pwrite;
    assign prdata  = rdata_reg;

    // oscillator setting decides who owns pins 6 and 7
    assign pin6_io     = (osc_reg == `PAM_OSC_RC_OSC_WITH_PORT_PIN) || (osc_reg == `PAM_OSC_INTERNAL_OSC_WITH_PORT_PIN) ||
                         (osc_reg == `PAM_OSC_EXT_CLOCK_WITH_PORT_PIN);
    assign pin6_clkout = (osc_reg == `PAM_OSC_RC) ||
                         (osc_reg == `PAM_OSC_INTERNAL_OSC_WITH_CLOCK_OUT);
    // crystal modes, the pure rc mode and the external clock mode use pin 7 as the oscillator input
    assign pin7_io     = (osc_reg == `PAM_OSC_RC_OSC_WITH_PORT_PIN) || (osc_reg == `PAM_OSC_INTERNAL_OSC_WITH_PORT_PIN) ||
                         (osc_reg == `PAM_OSC_INTERNAL_OSC_WITH_CLOCK_OUT);
    assign oscillator_claims_pins = ~pin7_io;
    assign io_mask = {pin7_io, pin6_io, 6'h3f};

    assign cvr_oe   = cvr_reg[`PAM_CVR_OE_BIT];
    assign c1_route = (cmp_reg[2:0] == `PAM_CMP_MODE_C1C2O) ||
                      (cmp_reg[2:0] == `PAM_CMP_MODE_C1O);
    assign c2_route = (cmp_reg[2:0] == `PAM_CMP_MODE_C1C2O);

    // digital input buffer off for analog pins and the reference pin
    assign dig_in_dis = {2'b00, analog_sel[4], 1'b0, analog_sel[3],
                         analog_sel[2] | cvr_oe, analog_sel[1:0]};
    assign levels = pin_in & ~dig_in_dis & io_mask;

    assign analog_channel_en = analog_sel;
    assign comparator_one_inv_in_en    = analog_sel[0];
    assign comparator_two_noninv_in_en = analog_sel[2];
    assign comparator_reference_output = cvr_oe;
    assign timer_zero_clock_in = pin_in[4];
    // select only meaningful while software keeps the pin an input
    assign slave_select_in = pin_in[5] & dir_reg[5];

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            latch_reg <= `PAM_RST_LATCH;
            dir_reg   <= `PAM_RST_DIR;
            adsel_reg <= `PAM_RST_ADSEL;
            cmp_reg   <= `PAM_RST_CMP;
            cvr_reg   <= `PAM_RST_CVR;
            osc_reg   <= `PAM_RST_OSC;
        end
        else if (wr_en)
        begin
            case (paddr)
                `PAM_OFS_LEVELS: latch_reg <= pwdata[7:0];
                `PAM_OFS_LATCH:  latch_reg <= pwdata[7:0];
                `PAM_OFS_DIR:    dir_reg   <= pwdata[7:0];
                `PAM_OFS_ADSEL:  adsel_reg <= pwdata[7:0] & `PAM_ADSEL_MASK;
                `PAM_OFS_CMP:    cmp_reg   <= pwdata[7:0] & `PAM_CMP_WMASK;
                `PAM_OFS_CVR:    cvr_reg   <= pwdata[7:0];
                `PAM_OFS_OSC:    osc_reg   <= pwdata[2:0];
                default:         latch_reg <= latch_reg;
            endcase
        end
    end

    // read data captured in the setup cycle, held through the access phase
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rdata_reg <= 32'h00000000;
        else if (rd_en)
        begin
            case (paddr)
                `PAM_OFS_LEVELS: rdata_reg <= {24'h000000, levels};
                `PAM_OFS_LATCH:  rdata_reg <= {24'h000000, latch_reg & io_mask};
                `PAM_OFS_DIR:    rdata_reg <= {24'h000000, dir_reg & io_mask};
                `PAM_OFS_ADSEL:  rdata_reg <= {24'h000000, adsel_reg};
                `PAM_OFS_CMP:    rdata_reg <= {24'h000000, comparator_two_result,
                                               comparator_one_result, cmp_reg[5:0]};
                `PAM_OFS_CVR:    rdata_reg <= {24'h000000, cvr_reg};
                `PAM_OFS_OSC:    rdata_reg <= {29'h00000000, osc_reg};
                default:         rdata_reg <= 32'h00000000;
            endcase
        end
    end

    // pin drivers registered; oe low means driving
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_out  <= 8'h00;
            pin_oe_n <= 8'hff;
        end
        else
        begin
            pin_out  <= latch_reg;
            pin_oe_n <= dir_reg;
            if (c1_route && !dir_reg[4])
                pin_out[4] <= comparator_one_result;
            if (c2_route && !dir_reg[5])
                pin_out[5] <= comparator_two_result;
            if (cvr_oe)
                pin_oe_n[2] <= 1'b1;
            if (pin6_clkout)
            begin
                pin_out[6]  <= cyc_clk;
                pin_oe_n[6] <= 1'b0;
            end
            else if (!pin6_io)
                pin_oe_n[6] <= 1'b1;
            if (!pin7_io)
                pin_oe_n[7] <= 1'b1;
        end
    end
endmodule // pam_port_a

// ===== dv/pam_port_a_asserts.sv
// concurrent checks on the ports of the port a pin mux block
`timescale 1ns/10ps
module pam_port_a_asserts
(
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire [7:0]  pin_out,
    input wire [7:0]  pin_oe_n,
    input wire        comparator_one_result,
    input wire        comparator_two_result,
    input wire [4:0]  analog_channel_en,
    input wire        comparator_one_inv_in_en,
    input wire        comparator_two_noninv_in_en,
    input wire        comparator_reference_output,
    input wire        oscillator_claims_pins
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    reg  [7:0] lat_reg;
    reg  [7:0] dir_reg;
    reg  [2:0] cm_reg;
    wire       wr_go = psel && penable && pwrite;
    // shadow copies, so pin checks need not trust the design's own registers
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lat_reg <= 8'h00;
            dir_reg <= 8'hff;
            cm_reg  <= 3'h7;
        end
        else if (wr_go)
        begin
            if (paddr == 12'h000 || paddr == 12'h004) lat_reg <= pwdata[7:0];
            if (paddr == 12'h008) dir_reg <= pwdata[7:0];
            if (paddr == 12'h010) cm_reg <= pwdata[2:0];
        end
    end
    sequence s_rd_claimed;
        psel && penable && !pwrite && (paddr == 12'h004 || paddr == 12'h008)
            && oscillator_claims_pins;
    endsequence
    a_inv_route: assert property (comparator_one_inv_in_en == analog_channel_en[0])
        else $error("comparator one input route wrong");
    a_noninv_route: assert property (comparator_two_noninv_in_en == analog_channel_en[2])
        else $error("comparator two input route wrong");
    a_drive_latch: assert property ((pin_out[3:0] & ~pin_oe_n[3:0]) ==
        ($past(lat_reg[3:0]) & ~pin_oe_n[3:0])) else $error("driven pin differs from latch");
    a_dir_float: assert property ({pin_oe_n[3], pin_oe_n[1:0]} ==
        {$past(dir_reg[3]), $past(dir_reg[1:0])}) else $error("pin enable differs from direction");
    a_cmp1_over: assert property (!pin_oe_n[4] && ($past(cm_reg) == 3'h3 || $past(cm_reg) == 3'h5)
        |-> pin_out[4] == $past(comparator_one_result)) else $error("pin 4 lacks comparator one");
    a_cmp2_over: assert property (!pin_oe_n[5] && $past(cm_reg) == 3'h3
        |-> pin_out[5] == $past(comparator_two_result)) else $error("pin 5 lacks comparator two");
    a_ref_pin2: assert property (comparator_reference_output && $past(comparator_reference_output)
        |-> pin_oe_n[2]) else $error("pin 2 driven while reference out");
    a_claim_pin7: assert property (oscillator_claims_pins && $past(oscillator_claims_pins)
        |-> pin_oe_n[7]) else $error("pin 7 driven while claimed");
    a_read_zero: assert property (s_rd_claimed |-> prdata[7] == 1'b0)
        else $error("claimed pin bit reads nonzero");
endmodule // pam_port_a_asserts
bind pam_port_a pam_port_a_asserts u_chk (.*);

// ===== dv/pam_board.sv
// board circuitry model driving the port a pads
`timescale 1ns/10ps
module pam_board
(
    input  wire [7:0] pin_out,
    input  wire [7:0] pin_oe_n,
    input  wire [7:0] ext,
    output wire [7:0] pin_in
);
    // a pad the device drives shows its level, otherwise the board's own drive wins
    assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext);
endmodule // pam_board

// ===== dv/tb_port_a_pin_mux_io.sv
// self-checking bench for the port a pin mux block
`timescale 1ns/10ps
module tb_port_a_pin_mux_io;
    reg         pclk = 1'b0;
    reg         presetn = 1'b0;
    reg         psel = 1'b0;
    reg         penable = 1'b0;
    reg         pwrite = 1'b0;
    reg  [11:0] paddr = 12'h000;
    reg  [31:0] pwdata = 32'h0;
    reg         c1 = 1'b1;
    reg         c2 = 1'b0;
    reg  [7:0]  ext = 8'hff;
    wire [31:0] prdata;
    wire        pready, pslverr, c1_in, c2_in, ref_out, t0_in, ss_in, claims;
    wire [7:0]  pin_in, pin_out, pin_oe_n;
    wire [4:0]  an_en;
    integer     bad_count = 0;
    integer     n_checks = 0;
    reg  [31:0] rd;
    reg         err = 1'b0;
    always #2.5 pclk = ~pclk;
    pam_port_a DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .comparator_one_result(c1), .comparator_two_result(c2), .analog_channel_en(an_en),
        .comparator_one_inv_in_en(c1_in), .comparator_two_noninv_in_en(c2_in),
        .comparator_reference_output(ref_out), .timer_zero_clock_in(t0_in),
        .slave_select_in(ss_in), .oscillator_claims_pins(claims));
    pam_board u_board (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext(ext), .pin_in(pin_in));
    task results;
    begin
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    end
    endtask
    task chk(input string n, input [31:0] e, input [31:0] g);
    begin
        n_checks = n_checks + 1;
        if (g !== e)
        begin
            $display("ERROR %s expected %h seen %h", n, e, g);
            bad_count = bad_count + 1;
        end
    end
    endtask
    task xfer(input w, input [11:0] a, input [31:0] d);
        integer k;
    begin
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        @(posedge pclk);
        while (pready !== 1'b1 && k < 16)
        begin
            k = k + 1;
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (k == 16)
        begin
            bad_count = bad_count + 1;
            results;
        end
    end
    endtask
    task settle;
    begin
        repeat (2) @(posedge pclk);
        #1;
    end
    endtask
    task t_main;
        integer c;
        integer k;
        reg [7:0] e;
    begin
        xfer(0, 12'h008, 0);
        chk("dir", 32'h3f, rd);
        chk("slverr", 32'h0, {31'h0, err});
        xfer(0, 12'h000, 0);
        chk("levels", 32'h10, rd);
        chk("analog", 32'h1f, {27'h0, an_en});
        chk("route", 32'h3, {30'h0, c1_in, c2_in});
        chk("t0", 32'h1, {31'h0, t0_in});
        // unmapped word: write must be dropped, read gives zero with an error answer
        xfer(1, 12'h01c, 32'hff);
        chk("slverr", 32'h1, {31'h0, err});
        xfer(0, 12'h01c, 0);
        chk("unmapped", 32'h0, rd);
        chk("slverr", 32'h1, {31'h0, err});
        $display("done reset");
        xfer(1, 12'h00c, 32'h0f);
        xfer(1, 12'h000, 32'ha5);
        xfer(1, 12'h008, 32'h00);
        xfer(0, 12'h004, 0);
        chk("latch", 32'h25, rd);
        xfer(0, 12'h000, 0);
        chk("levels", 32'h25, rd);
        settle;
        chk("analog", 32'h0, {27'h0, an_en});
        chk("oe", 32'h0, {24'h0, pin_oe_n[5:0]});
        $display("done latch");
        xfer(1, 12'h010, 32'h03);
        settle;
        chk("pin54", 32'h1, {30'h0, pin_out[5:4]});
        xfer(1, 12'h010, 32'h05);
        settle;
        chk("pin54", 32'h3, {30'h0, pin_out[5:4]});
        xfer(1, 12'h010, 32'h07);
        xfer(1, 12'h014, 32'h40);
        settle;
        chk("oe2", 32'h1, {31'h0, pin_oe_n[2] & ref_out});
        xfer(0, 12'h000, 0);
        chk("levels", 32'h21, rd);
        xfer(1, 12'h014, 32'h00);
        $display("done alternate");
        for (c = 0; c < 8; c = c + 1)
        begin
            xfer(1, 12'h018, c);
            xfer(1, 12'h004, 32'hff);
            xfer(0, 12'h004, 0);
            e = {(c == 4 || c == 5 || c == 6), (c == 4 || c == 5 || c == 7), 6'h3f};
            chk("latch", {24'h0, e}, rd);
            chk("claim", {31'h0, ~e[7]}, {31'h0, claims});
            k = 0;
            repeat (4)
            begin
                @(posedge pclk);
                #1;
                k = k + pin_out[6];
            end
            if (c == 3 || c == 6) chk("clk6", 2, k);
        end
        xfer(1, 12'h008, 32'h20);
        settle;
        chk("select", 32'h1, {31'h0, ss_in});
        $display("done oscillator");
    end
    endtask
    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_main;
        results;
    end
endmodule // tb_port_a_pin_mux_io
